// ===== verilog/sfd_channel_diagnostic_registers.sv
// switch fault diagnostics: reports, fault pin, output and clamp control, ahb-lite registers
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sfd_channel_diagnostic_registers (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	// ahb-lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	// monitor conditions
	input  wire logic                   switch_supply_low_raw,
	input  wire logic                   switch_supply_over_raw,
	input  wire logic                   switch_supply_under_raw,
	input  wire logic                   switch_supply_unpowered,
	input  wire logic                   logic_supply_under_raw,
	input  wire logic [sfd_pkg::NCH-1:0] overtemp_threshold_raw,
	input  wire logic [sfd_pkg::NCH-1:0] current_limit_threshold_raw,
	input  wire logic [sfd_pkg::NCH-1:0] channel_input_pin,
	// consequences
	output logic [sfd_pkg::NCH-1:0]     channel_drive,
	output logic                        clamp_low,
	output logic                        fault_indicator_n_o,
	output logic                        fault_indicator_n_oe,
	output logic                        irq
);
	import sfd_pkg::*;

	// ***********************************************************
	// declarations
	// ***********************************************************
	logic [REP_W-1:0] report;            // held diagnostic reports
	logic [REP_W-1:0] cond;              // live conditions in report layout
	logic [REP_W-1:0] next_report;       // report after this cycle
	logic [REP_W-1:0] fault_mask;        // fault_indicator_mask
	logic [REP_W-1:0] aclr_mask;         // auto_clear_mask
	logic [REP_W-1:0] clr_pulse;         // clear_report_register write strobe
	logic [REP_W-1:0] irq_status;        // sticky interrupt status
	logic [REP_W-1:0] irq_mask;          // interrupt enables
	logic [REP_W-1:0] rep_rise;          // reports newly raised
	logic [REP_W-1:0] report_d;          // report one cycle ago
	logic [NCH-1:0]   chen;              // channel_enable_field
	logic [NCH-1:0]   ch_on_req;         // commanded on, pin or register
	logic [NCH-1:0]   ot_f;              // filtered over temperature
	logic             all_ot;            // every channel hot
	logic             all_off;           // global shutdown
	logic             logic_uv_f;        // filtered logic supply undervoltage
	logic [7:0]       master_reg;        // master_diagnostic_register image
	logic [7:0]       chdiag_reg;        // channel_diagnostic_registers image
	logic             wr_pend;           // write data phase pending
	logic [7:0]       wr_addr;           // address of pending write
	logic             addr_ok;           // valid address phase
	logic             wr_en;             // write data phase this cycle
	logic [31:0]      rd_mux;            // read data selected at address phase

	// ***********************************************************
	// persistence filter
	// ***********************************************************
	sfd_filt_if fi ();

	// supply and temperature conditions pass through the dwell filter, except switch_supply_unpowered, which is used unfiltered
	assign fi.raw[F_SUP_LOW]  = switch_supply_low_raw;
	assign fi.raw[F_SUP_OVER] = switch_supply_over_raw;
	assign fi.raw[F_SUP_UNDR] = switch_supply_under_raw;
	assign fi.raw[F_LOG_UV]   = logic_supply_under_raw;
	assign fi.raw[F_OT0 +: NCH] = overtemp_threshold_raw;

	sfd_persist u_persist (
		.clock (clock),
		.rstn  (rstn),
		.fi    (fi)
	);

	assign ot_f       = fi.stable[F_OT0 +: NCH];
	assign logic_uv_f = fi.stable[F_LOG_UV];
	assign all_ot     = &ot_f;

	// ***********************************************************
	// live conditions in report layout
	// ***********************************************************
	// over current is not filtered: the channel must drop at once
	always_comb begin
		cond                = '0;
		cond[B_SUP_LOW]     = fi.stable[F_SUP_LOW];
		cond[B_SUP_OVER]    = fi.stable[F_SUP_OVER];
		cond[B_SUP_UNDR]    = fi.stable[F_SUP_UNDR];
		cond[B_ALL_OT]      = all_ot;
		cond[B_LINK]        = switch_supply_unpowered;
		cond[B_OT0 +: NCH]  = ot_f;
		cond[B_OC0 +: NCH]  = current_limit_threshold_raw & ch_on_req;
	end

	// ***********************************************************
	// report latches
	// ***********************************************************
	// a live condition wins over any clear, so nothing is lost
	assign next_report = cond | (report & ~aclr_mask & ~clr_pulse);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			report   <= '0;
			report_d <= '0;
		end else begin
			report   <= next_report;
			report_d <= report;
		end
	end

	// ***********************************************************
	// register images
	// ***********************************************************
	// undervoltage drives both field bits, giving code 11
	always_comb begin
		master_reg         = '0;
		master_reg[M_OS]   = report[B_SUP_OVER] | report[B_SUP_UNDR];
		master_reg[M_LOW]  = report[B_SUP_LOW] | report[B_SUP_UNDR];
		master_reg[M_OT]   = report[B_ALL_OT];
		master_reg[M_LINK] = report[B_LINK];
		chdiag_reg         = '0;
		chdiag_reg[0 +: NCH]     = report[B_OT0 +: NCH];
		chdiag_reg[D_OC0 +: NCH] = report[B_OC0 +: NCH];
	end

	// ***********************************************************
	// output and clamp control
	// ***********************************************************
	// link error holds outputs off until its report is cleared
	assign all_off   = all_ot | fi.stable[F_SUP_UNDR] | logic_uv_f | report[B_LINK];
	assign ch_on_req = channel_input_pin | chen;

	// drive is registered; hot or overloaded channels stay off
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			channel_drive <= '0;
		end else if (all_off) begin
			channel_drive <= '0;
		end else begin
			channel_drive <= ch_on_req & ~ot_f & ~cond[B_OC0 +: NCH];
		end
	end

	// one clamp level shared by every channel
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			clamp_low <= 1'b0;
		end else begin
			clamp_low <= fi.stable[F_SUP_OVER] | (|ot_f);
		end
	end

	// ***********************************************************
	// fault indicator
	// ***********************************************************
	// open drain: pin only ever pulled low, so the data is fixed low
	// logic supply undervoltage has no mask bit and always pulls
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fault_indicator_n_oe <= 1'b0;
		end else begin
			fault_indicator_n_oe <= (|(report & fault_mask)) | logic_uv_f;
		end
	end
	assign fault_indicator_n_o = 1'b0;

	// ***********************************************************
	// interrupts
	// ***********************************************************
	assign rep_rise = report & ~report_d;

	// a new event in the clear cycle survives the write of one
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irq_status <= '0;
		end else if (wr_en && wr_addr == A_IRQST) begin
			irq_status <= (irq_status & ~hwdata[REP_W-1:0]) | rep_rise;
		end else begin
			irq_status <= irq_status | rep_rise;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ***********************************************************
	// ahb-lite slave
	// ***********************************************************
	// zero wait states, always okay; hsize ignored, word access only
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_ok   = hsel & htrans[1] & hready;
	assign wr_en     = wr_pend;

	// capture the address phase of a write
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end else begin
			wr_pend <= addr_ok & hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// read select; unmapped offsets read zero
	always_comb begin
		rd_mux = '0;
		unique case (haddr[7:0])
			A_MASTER: rd_mux[7:0]       = master_reg;
			A_CHDIAG: rd_mux[7:0]       = chdiag_reg;
			A_CHEN:   rd_mux[NCH-1:0]   = chen;
			A_FMASK:  rd_mux[REP_W-1:0] = fault_mask;
			A_ACLR:   rd_mux[REP_W-1:0] = aclr_mask;
			A_IRQST:  rd_mux[REP_W-1:0] = irq_status;
			A_IRQMSK: rd_mux[REP_W-1:0] = irq_mask;
			default:  rd_mux = '0;
		endcase
	end

	// read data is taken at the address phase and stands in the data phase
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hrdata <= '0;
		end else if (addr_ok && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	// writable configuration registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			chen       <= CHEN_RST;
			fault_mask <= FMASK_RST;
			aclr_mask  <= ACLR_RST;
			irq_mask   <= IRQMSK_RST;
		end else if (wr_en) begin
			unique case (wr_addr)
				A_CHEN:   chen       <= hwdata[NCH-1:0];
				A_FMASK:  fault_mask <= hwdata[REP_W-1:0];
				A_ACLR:   aclr_mask  <= hwdata[REP_W-1:0];
				A_IRQMSK: irq_mask   <= hwdata[REP_W-1:0];
				default:  ;
			endcase
		end
	end

	// clear strobe lasts the data phase cycle only
	assign clr_pulse = (wr_en && wr_addr == A_CLR) ? hwdata[REP_W-1:0] : '0;
endmodule
`default_nettype wire

// ===== inc/sfd_pkg.sv
// package of constants shared by the switch fault diagnostics block
`default_nettype none
package sfd_pkg;
	// ***********************************************************
	// sizes
	// ***********************************************************
	localparam int NCH    = 4;              // output channels
	localparam int FILT_N = 8;              // persistence-filtered conditions
	localparam int REP_W  = 16;             // report vector width

	// ***********************************************************
	// timing
	// ***********************************************************
	localparam int CLK_MHZ          = 50;   // system clock rate
	localparam int MEASURE_TIME_NS  = 10000;  // least dwell before a state change
	localparam int PERSIST_CYC      = (MEASURE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int PERSIST_W        = 10;   // counter width, holds PERSIST_CYC
	localparam logic [PERSIST_W-1:0] PERSIST_LAST = PERSIST_W'(PERSIST_CYC - 1);

	// ***********************************************************
	// filter input positions
	// ***********************************************************
	localparam int F_SUP_LOW  = 0;          // switch supply low
	localparam int F_SUP_OVER = 1;          // switch supply over voltage
	localparam int F_SUP_UNDR = 2;          // switch supply under voltage
	localparam int F_LOG_UV   = 3;          // logic supply under voltage
	localparam int F_OT0      = 4;          // first channel over temperature

	// ***********************************************************
	// report vector layout (masks, clear, irq use it too)
	// ***********************************************************
	localparam int B_SUP_LOW  = 0;          // low voltage warning
	localparam int B_SUP_OVER = 1;          // overvoltage constraint
	localparam int B_SUP_UNDR = 2;          // undervoltage shutdown
	localparam int B_ALL_OT   = 3;          // all channel over temperature
	localparam int B_LINK     = 4;          // link error
	localparam int B_OT0      = 8;          // per channel over temperature
	localparam int B_OC0      = 12;         // per channel over current

	// ***********************************************************
	// master diagnostic register fields
	// ***********************************************************
	localparam int M_LOW  = 4;              // supply low
	localparam int M_OS   = 5;              // supply out of spec
	localparam int M_OT   = 6;              // all channel shutdown
	localparam int M_LINK = 7;              // link error
	localparam int D_OC0  = 4;              // channel channel_diagnostic_registers: over current base

	// ***********************************************************
	// register offsets (byte addresses)
	// ***********************************************************
	localparam logic [7:0] A_MASTER = 8'h00;  // master_diagnostic_register
	localparam logic [7:0] A_CHDIAG = 8'h04;  // channel_diagnostic_registers
	localparam logic [7:0] A_CHEN   = 8'h08;  // channel_enable_field
	localparam logic [7:0] A_FMASK  = 8'h0c;  // fault_indicator_mask
	localparam logic [7:0] A_ACLR   = 8'h10;  // auto_clear_mask
	localparam logic [7:0] A_CLR    = 8'h14;  // clear_report_register
	localparam logic [7:0] A_IRQST  = 8'h18;  // interrupt status, write one to clear
	localparam logic [7:0] A_IRQMSK = 8'h1c;  // interrupt mask

	// ***********************************************************
	// reset values
	// ***********************************************************
	localparam logic [REP_W-1:0] FMASK_RST  = 16'hff1e;  // every constraint and shutdown
	localparam logic [REP_W-1:0] ACLR_RST   = 16'hffff;  // all reports clear themselves
	localparam logic [REP_W-1:0] IRQMSK_RST = 16'h0000;  // interrupts masked
	localparam logic [NCH-1:0]   CHEN_RST   = 4'h0;      // all channels commanded off
endpackage
`default_nettype wire

// ===== inc/sfd_filt_if.sv
// interface between the diagnostics top and its persistence filter
`timescale 1ns/1ps
`default_nettype none
interface sfd_filt_if;
	logic [sfd_pkg::FILT_N-1:0] raw;      // sampled conditions
	logic [sfd_pkg::FILT_N-1:0] stable;   // conditions after dwell check
	modport filt (input raw, output stable);
	modport user (output raw, input stable);
endinterface
`default_nettype wire

// ===== verilog/sfd_persist.sv
// persistence filter: a condition changes only after it held for the dwell time
`timescale 1ns/1ps
`default_nettype none
module sfd_persist (
	input  wire logic  clock,
	input  wire logic  rstn,
	sfd_filt_if.filt   fi
);
	import sfd_pkg::*;

	// ***********************************************************
	// one counter per condition
	// ***********************************************************
	genvar g;
	generate
		for (g = 0; g < FILT_N; g++) begin : g_bit
			logic [PERSIST_W-1:0] cnt;   // cycles the new level has held
			logic                 st;    // reported level

			// restart on any bounce, so short excursions never report
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					cnt <= '0;
					st  <= 1'b0;
				end else if (fi.raw[g] == st) begin
					cnt <= '0;
				end else if (cnt == PERSIST_LAST) begin
					st  <= fi.raw[g];
					cnt <= '0;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			assign fi.stable[g] = st;
		end
	endgenerate
endmodule
`default_nettype wire

// ===== tb/sfd_channel_diagnostic_registers_asserts.sv
// concurrent checks on the switch fault diagnostics top ports
`timescale 1ns/1ps
`default_nettype none
module sfd_channel_diagnostic_registers_asserts
	import sfd_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    rstn,
	input wire logic                    switch_supply_over_raw,
	input wire logic                    switch_supply_unpowered,
	input wire logic                    logic_supply_under_raw,
	input wire logic [sfd_pkg::NCH-1:0] overtemp_threshold_raw,
	input wire logic [sfd_pkg::NCH-1:0] current_limit_threshold_raw,
	input wire logic [sfd_pkg::NCH-1:0] channel_input_pin,
	input wire logic [sfd_pkg::NCH-1:0] channel_drive,
	input wire logic                    clamp_low,
	input wire logic                    fault_indicator_n_oe,
	input wire logic                    irq
);
	// ***********************************************************
	// dwell counters
	// ***********************************************************
	logic [9:0] cnt_ovr;  // cycles of over voltage held
	logic [9:0] cnt_hot;  // cycles of any channel hot
	logic [9:0] cnt_all;  // cycles of every channel hot
	logic [9:0] cnt_luv;  // cycles of logic supply low

	// saturate so a long fault never wraps back to a small count
	function automatic logic [9:0] step(input logic c, input logic [9:0] v);
		return c ? v + 10'(v != 10'h3ff) : 10'h0;
	endfunction

	// any bounce restarts a count, as the filter does
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			{cnt_ovr, cnt_hot, cnt_all, cnt_luv} <= 40'h0;
		end else begin
			cnt_ovr <= step(switch_supply_over_raw, cnt_ovr);
			cnt_hot <= step(|overtemp_threshold_raw, cnt_hot);
			cnt_all <= step(&overtemp_threshold_raw, cnt_all);
			cnt_luv <= step(logic_supply_under_raw, cnt_luv);
		end
	end

	// ***********************************************************
	// properties
	// ***********************************************************
	default clocking dc @(posedge clock); endclocking
	default disable iff (!rstn);

	oc_off_a: assert property (channel_input_pin[0] && current_limit_threshold_raw[0]
		|-> ##[1:2] !channel_drive[0])
		else $error("channel 0 left on under over current");
	oc_fault_a: assert property ((channel_input_pin & current_limit_threshold_raw) != 4'h0
		|-> ##[1:2] fault_indicator_n_oe)
		else $error("over current did not pull the fault line");
	luv_off_a: assert property (cnt_luv == 10'd505 |-> fault_indicator_n_oe && channel_drive == 4'h0)
		else $error("logic supply low left outputs on or line free");
	early_hold_a: assert property ($rose(clamp_low) |-> cnt_ovr > 10'd495 || cnt_hot > 10'd495)
		else $error("clamp changed before the dwell time");
	hot_off_a: assert property (cnt_hot == 10'd505 |-> clamp_low
		&& (channel_drive & overtemp_threshold_raw) == 4'h0 && fault_indicator_n_oe)
		else $error("hot channel not constrained");
	all_hot_a: assert property (cnt_all == 10'd505 |-> (channel_drive == 4'h0) [*3])
		else $error("all hot left an output on");
	ovr_clamp_a: assert property (cnt_ovr == 10'd505 |-> clamp_low)
		else $error("over voltage without low clamp");
	link_off_a: assert property (switch_supply_unpowered [*3] |=> channel_drive == 4'h0)
		else $error("unpowered switch side left outputs on");

	cover property ($rose(irq));
	cover property (cnt_all == 10'd505);
	cover property ($rose(fault_indicator_n_oe));
endmodule
`default_nettype wire

// ===== tb/sfd_host.sv
// host model: ahb-lite master transfers and the pulled-up fault line
`timescale 1ns/1ps
`default_nettype none
module sfd_host (
	input  wire logic        clock,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        fault_o,
	input  wire logic        fault_oe,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	output logic             fault_indicator_n
);
	// open drain: the board pull-up wins whenever the device lets go
	assign fault_indicator_n = fault_oe ? fault_o : 1'b1;

	// idle bus from time zero
	initial begin
		{hsel, hwrite, htrans, hsize} = 7'h0;
		{haddr, hwdata} = 64'h0;
	end

	// one single word; call right after a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		hsize <= 3'b010;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the switch fault diagnostics block
`timescale 1ns/1ps
`default_nettype none
bind sfd_channel_diagnostic_registers sfd_channel_diagnostic_registers_asserts sfd_channel_diagnostic_registers_asserts_inst (.clock, .rstn, .switch_supply_over_raw,
	.switch_supply_unpowered, .logic_supply_under_raw, .overtemp_threshold_raw, .current_limit_threshold_raw,
	.channel_input_pin, .channel_drive, .clamp_low, .fault_indicator_n_oe, .irq);
module testbench
	import sfd_pkg::*;
;
	// ***********************************************************
	// signals
	// ***********************************************************
	logic        clock = 1'b0, rstn = 1'b0;                 // 50 MHz clock, async reset
	logic        hsel, hwrite, hreadyout, hresp;           // bus control
	logic [1:0]  htrans;                                   // bus transfer kind
	logic [2:0]  hsize;                                    // bus size
	logic [31:0] haddr, hwdata, hrdata, v;                 // bus data, v = last read
	logic        switch_supply_low_raw, switch_supply_over_raw, switch_supply_under_raw;
	logic        switch_supply_unpowered, logic_supply_under_raw;
	logic [3:0]  overtemp_threshold_raw, current_limit_threshold_raw, channel_input_pin, channel_drive;
	logic        clamp_low, fault_indicator_n_o, fault_indicator_n_oe, irq, fault_indicator_n;
	int          i, n_mismatch = 0, n_tests = 0, cycles = 0;

	typedef struct packed {
		logic [3:0]  pin;  // channel inputs
		logic [3:0]  oc;   // over current flags
		logic        wr;   // write before the read
		logic [7:0]  a;    // byte address
		logic [31:0] d;    // write data
		logic [31:0] e;    // expected read
	} sfd_row_s;
	sfd_row_s rows [14] = '{
		'{4'h0, 4'h0, 1'b0, A_FMASK, 32'h0, 32'hff1e}, '{4'h0, 4'h0, 1'b0, A_ACLR, 32'h0, 32'hffff},
		'{4'h0, 4'h0, 1'b0, A_IRQMSK, 32'h0, 32'h0}, '{4'h0, 4'h0, 1'b0, A_CHEN, 32'h0, 32'h0},
		'{4'h0, 4'h0, 1'b1, A_IRQMSK, 32'h1234a5a5, 32'ha5a5}, '{4'h0, 4'h0, 1'b1, 8'h20, 32'hffffffff, 32'h0},
		'{4'h0, 4'h0, 1'b1, A_MASTER, 32'hff, 32'h0}, '{4'h0, 4'h0, 1'b1, A_CLR, 32'hffff, 32'h0},
		'{4'h1, 4'h1, 1'b0, A_CHDIAG, 32'h0, 32'h10}, '{4'h8, 4'h8, 1'b0, A_CHDIAG, 32'h0, 32'h80},
		'{4'h0, 4'hf, 1'b0, A_CHDIAG, 32'h0, 32'h0}, '{4'h0, 4'h0, 1'b1, A_CHEN, 32'h1, 32'h1},
		'{4'h0, 4'h1, 1'b0, A_CHDIAG, 32'h0, 32'h10}, '{4'h0, 4'h0, 1'b1, A_CHEN, 32'h0, 32'h0}};

	sfd_channel_diagnostic_registers sfd_channel_diagnostic_registers_inst (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .switch_supply_low_raw, .switch_supply_over_raw, .switch_supply_under_raw,
		.switch_supply_unpowered, .logic_supply_under_raw, .overtemp_threshold_raw, .current_limit_threshold_raw,
		.channel_input_pin, .channel_drive, .clamp_low, .fault_indicator_n_o, .fault_indicator_n_oe, .irq);
	sfd_host sfd_host_inst (.clock, .hready(hreadyout), .hrdata, .fault_o(fault_indicator_n_o),
		.fault_oe(fault_indicator_n_oe), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .fault_indicator_n);

	// ***********************************************************
	// helpers
	// ***********************************************************
	always #10 clock = ~clock;

	// hang guard, well above the planned run length
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		sfd_host_inst.bus(1'b0, a, 32'h0, v);
		check(v, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		sfd_host_inst.bus(1'b1, a, d, v);
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ***********************************************************
	// sequence
	// ***********************************************************
	initial begin
		{switch_supply_low_raw, switch_supply_over_raw, switch_supply_under_raw} = 3'h0;
		{switch_supply_unpowered, logic_supply_under_raw} = 2'h0;
		{overtemp_threshold_raw, current_limit_threshold_raw, channel_input_pin} = 12'h0;
		repeat (3) @(posedge clock);
		check(32'({fault_indicator_n, hreadyout, hresp, irq, clamp_low, channel_drive}), 32'h180);
		rstn <= 1'b1;
		@(posedge clock);
		// table of register and over current cases
		foreach (rows[k]) begin
			channel_input_pin <= rows[k].pin;
			current_limit_threshold_raw <= rows[k].oc;
			repeat (2) @(posedge clock);
			if (rows[k].wr) wr(rows[k].a, rows[k].d);
			rd(rows[k].a, rows[k].e);
		end
		// supply field walk: early read keeps old code
		channel_input_pin <= 4'hf;
		for (int k = 0; k < 4; k++) begin
			i = (k + 1) % 4;
			{switch_supply_under_raw, switch_supply_over_raw, switch_supply_low_raw} <= 3'((i == 0) ? 0 : 1 << (i - 1));
			repeat (400) @(posedge clock);
			rd(A_MASTER, 32'(k) << 4);
			repeat (110) @(posedge clock);
			rd(A_MASTER, 32'(i) << 4);
			check(32'(fault_indicator_n), 32'(i < 2));
		end
		// logic supply low: pin and outputs only, no register bit
		logic_supply_under_raw <= 1'b1;
		repeat (510) @(posedge clock);
		check(32'({fault_indicator_n, channel_drive}), 32'h0);
		rd(A_MASTER, 32'h0);
		logic_supply_under_raw <= 1'b0;
		// one channel hot, then all hot
		overtemp_threshold_raw <= 4'h1;
		repeat (510) @(posedge clock);
		check(32'({clamp_low, channel_drive}), 32'h1e);
		rd(A_CHDIAG, 32'h1);
		overtemp_threshold_raw <= 4'hf;
		repeat (510) @(posedge clock);
		rd(A_MASTER, 32'h40);
		rd(A_CHDIAG, 32'hf);
		overtemp_threshold_raw <= 4'h0;
		// over voltage masked off the fault line, then reset mid-run
		wr(A_FMASK, 32'hff1c);
		switch_supply_over_raw <= 1'b1;
		repeat (510) @(posedge clock);
		check(32'({fault_indicator_n, clamp_low}), 32'h3);
		switch_supply_over_raw <= 1'b0;
		rstn <= 1'b0;
		@(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		rd(A_FMASK, 32'hff1e);
		// held report, interrupt raise, clear and mask
		wr(A_ACLR, 32'hefff);
		wr(A_IRQMSK, 32'h1000);
		channel_input_pin <= 4'h1;
		current_limit_threshold_raw <= 4'h1;
		repeat (4) @(posedge clock);
		current_limit_threshold_raw <= 4'h0;
		repeat (4) @(posedge clock);
		check(32'(irq), 32'h1);
		rd(A_CHDIAG, 32'h10);
		wr(A_CLR, 32'h1000);
		wr(A_IRQST, 32'h1000);
		repeat (3) @(posedge clock);
		check(32'(irq), 32'h0);
		rd(A_CHDIAG, 32'h0);
		wr(A_IRQMSK, 32'h0);
		current_limit_threshold_raw <= 4'h1;
		repeat (4) @(posedge clock);
		check(32'(irq), 32'h0);
		rd(A_IRQST, 32'h1000);
		// unpowered switch side: link error, all off
		current_limit_threshold_raw <= 4'h0;
		channel_input_pin <= 4'h2;
		switch_supply_unpowered <= 1'b1;
		repeat (4) @(posedge clock);
		check(32'(channel_drive), 32'h0);
		rd(A_MASTER, 32'h80);
		switch_supply_unpowered <= 1'b0;
		repeat (4) @(posedge clock);
		check(32'(channel_drive), 32'h2);
		report_and_stop();
	end
endmodule
`default_nettype wire
